// *** hw/rfmc_mode_ctrl.sv ***
// Operating mode and transmit driver control of the reader front end
`timescale 1ns/1ps
`include "rfmc_cfg.svh"

module rfmc_mode_ctrl #(
   parameter int TICK_CYC = `RFMC_WU_TICK_US * `RFMC_CLK_MHZ
) (
   input  wire  logic                     clk,
   input  wire  logic                     rst_n,
   input  wire  logic [`RFMC_OPC_W-1:0]   op_ctrl,
   input  wire  rfmc_pkg::rfmc_drv_cfg_t  drv_cfg,
   input  wire  logic                     cfg_wr,
   input  wire  logic                     buf_req,
   input  wire  logic                     osc_ok,
   input  wire  logic                     mod_active,
   input  wire  logic [7:0]               wake_period,
   input  wire  logic                     wake_src_amp,
   input  wire  logic [7:0]               wake_ref,
   input  wire  logic [7:0]               wake_delta,
   input  wire  rfmc_pkg::rfmc_meas_t     meas,
   output logic [2:0]                     mode,
   output logic                           osc_en,
   output logic                           regulator_en,
   output logic                           aat_out_en,
   output logic                           lp_osc_en,
   output logic                           rx_on,
   output logic                           tx_on,
   output logic                           buf_grant,
   output logic                           osc_stable_irq,
   output logic                           meas_start,
   output logic                           wake_irq,
   output logic [`RFMC_SEG_N-1:0]         antenna_driver_out_a,
   output logic [`RFMC_SEG_N-1:0]         antenna_driver_out_b,
   output logic                           rx_input_b,
   output logic                           am_supply_en
);
   import rfmc_pkg::*;

   localparam int TW = $clog2(TICK_CYC + 1);

   generate
      if (TICK_CYC < 1) begin : g_chk
         $error("TICK_CYC must be at least one");
      end
   endgenerate

   // Segments left on for a resistance code: upper segments drop first
   function automatic logic [`RFMC_SEG_N-1:0] seg_mask(input logic [3:0] code);
      if (code > `RFMC_DRES_MAXSH)
         seg_mask = `RFMC_SEG_LSB;
      else
         seg_mask = `RFMC_SEG_ALL >> code;
   endfunction : seg_mask

   // Distance of a measurement from its reference
   function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
      abs_diff = (a > b) ? (a - b) : (b - a);
   endfunction : abs_diff

   rfmc_state_t           state_q, state_d;
   rfmc_drv_cfg_t         cfg_q, cfg_d;
   logic                  osc_seen_q, osc_seen_d;
   logic                  osc_irq_q, osc_irq_d;
   logic                  rx_q, rx_d, tx_q, tx_d, grant_q, grant_d;
   logic [TW-1:0]         tick_q, tick_d;
   logic [7:0]            per_q, per_d;
   logic                  mst_q, mst_d, wirq_q, wirq_d;
   logic [`RFMC_SEG_N-1:0] seg_a_q, seg_a_d, seg_b_q, seg_b_d;
   logic                  rxb_q, rxb_d, am_q, am_d;
   logic                  ready_q, ready_d, lpw_q, lpw_d;
   logic                  drive_a, drive_b;
   logic [7:0]            meas_val;

   // Mode selection from the operation control bits
   always_comb begin
      if (op_ctrl[`RFMC_OPC_EN])
         state_d = RFMC_READY;
      else if (op_ctrl == (`RFMC_OPC_RESET | (8'h01 << `RFMC_OPC_WU)))
         state_d = RFMC_WAKE;
      else
         state_d = RFMC_PDOWN;
   end

   // Configuration writes are taken in every mode; buffer only when ready
   always_comb begin
      cfg_d   = cfg_wr ? drv_cfg : cfg_q;
      grant_d = buf_req && (state_d == RFMC_READY);
      rx_d    = (state_d == RFMC_READY) && op_ctrl[`RFMC_OPC_RX_EN];
      tx_d    = (state_d == RFMC_READY) && op_ctrl[`RFMC_OPC_TX_EN];
      ready_d = (state_d == RFMC_READY);
      lpw_d   = (state_d == RFMC_WAKE);
   end

   // One interrupt per entry into ready once the oscillator settles
   always_comb begin
      osc_irq_d  = 1'b0;
      osc_seen_d = osc_seen_q;
      if (state_q != RFMC_READY) begin
         osc_seen_d = 1'b0;
      end else if (osc_ok && !osc_seen_q && state_d == RFMC_READY) begin // Not raised while leaving ready
         osc_irq_d  = 1'b1;
         osc_seen_d = 1'b1;
      end
   end

   // Wake-up timer and presence check
   always_comb begin
      tick_d   = '0;
      per_d    = '0;
      mst_d    = 1'b0;
      wirq_d   = 1'b0;
      meas_val = wake_src_amp ? meas.amplitude : meas.phase;
      if (state_q == RFMC_WAKE) begin
         per_d = per_q;
         if (tick_q == TW'(TICK_CYC - 1)) begin
            if (per_q + `RFMC_PER_ONE >= wake_period) begin
               mst_d = 1'b1;
               per_d = '0;
            end else begin
               per_d = per_q + `RFMC_PER_ONE;
            end
         end else begin
            tick_d = tick_q + TW'(1);
         end
         wirq_d = meas.valid && (abs_diff(meas_val, wake_ref) > wake_delta);
      end
   end

   // Antenna drivers, receiver input pair and modulation supply
   always_comb begin
      drive_a = tx_d && (!cfg_q.single_drv || !cfg_q.alt_driver_select);
      drive_b = tx_d && (!cfg_q.single_drv || cfg_q.alt_driver_select);
      seg_a_d = `RFMC_SEG_NONE;
      seg_b_d = `RFMC_SEG_NONE;
      if (!(mod_active && cfg_q.modulation_type_select == RFMC_MOD_OOK)) begin
         if (drive_a)
            seg_a_d = seg_mask(cfg_q.d_res);
         if (drive_b)
            seg_b_d = seg_mask(cfg_q.d_res);
      end
      rxb_d = cfg_q.single_drv && cfg_q.alt_driver_select;
      am_d  = tx_d && mod_active && (cfg_q.modulation_type_select == RFMC_MOD_AM);
   end

   // State registers, all cleared to power-down defaults
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= RFMC_PDOWN;
         cfg_q      <= '{1'b0, 1'b0, RFMC_MOD_OOK, `RFMC_DRES_RESET};
         osc_seen_q <= 1'b0;
         osc_irq_q  <= 1'b0;
         rx_q       <= 1'b0;
         tx_q       <= 1'b0;
         grant_q    <= 1'b0;
         tick_q     <= '0;
         per_q      <= '0;
         mst_q      <= 1'b0;
         wirq_q     <= 1'b0;
         seg_a_q    <= `RFMC_SEG_NONE;
         seg_b_q    <= `RFMC_SEG_NONE;
         rxb_q      <= 1'b0;
         am_q       <= 1'b0;
         ready_q    <= 1'b0;
         lpw_q      <= 1'b0;
      end else begin
         state_q    <= state_d;
         cfg_q      <= cfg_d;
         osc_seen_q <= osc_seen_d;
         osc_irq_q  <= osc_irq_d;
         rx_q       <= rx_d;
         tx_q       <= tx_d;
         grant_q    <= grant_d;
         tick_q     <= tick_d;
         per_q      <= per_d;
         mst_q      <= mst_d;
         wirq_q     <= wirq_d;
         seg_a_q    <= seg_a_d;
         seg_b_q    <= seg_b_d;
         rxb_q      <= rxb_d;
         am_q       <= am_d;
         ready_q    <= ready_d;
         lpw_q      <= lpw_d;
      end
   end

   // Outputs straight from flip-flops; regulator and oscillators follow the mode register, modulation supply follows transmit and modulation
   assign mode                 = state_q;
   assign osc_en               = ready_q;
   assign regulator_en         = ready_q;
   assign aat_out_en           = ready_q;
   assign lp_osc_en            = lpw_q;
   assign rx_on                = rx_q;
   assign tx_on                = tx_q;
   assign buf_grant            = grant_q;
   assign osc_stable_irq       = osc_irq_q;
   assign meas_start           = mst_q;
   assign wake_irq             = wirq_q;
   assign antenna_driver_out_a = seg_a_q;
   assign antenna_driver_out_b = seg_b_q;
   assign rx_input_b           = rxb_q;
   assign am_supply_en         = am_q;

   property p_pdown_zero;
      @(posedge clk) disable iff (!rst_n)
      (op_ctrl == `RFMC_OPC_RESET) |=> (mode == RFMC_PDOWN && !regulator_en && !osc_en);
   endproperty
   a_pdown_zero: assert property (p_pdown_zero) else $error("all-zero control not power-down");

   property p_ready_en;
      @(posedge clk) disable iff (!rst_n)
      op_ctrl[`RFMC_OPC_EN] |=> (osc_en && regulator_en && aat_out_en);
   endproperty
   a_ready_en: assert property (p_ready_en) else $error("enable did not start oscillator");

   property p_buf_refused;
      @(posedge clk) disable iff (!rst_n)
      (buf_req && !op_ctrl[`RFMC_OPC_EN]) |=> !buf_grant;
   endproperty
   a_buf_refused: assert property (p_buf_refused) else $error("buffer granted outside ready");

   property p_osc_irq;
      @(posedge clk) disable iff (!rst_n)
      (osc_stable_irq) |-> (mode == RFMC_READY) ##1 !osc_stable_irq;
   endproperty
   a_osc_irq: assert property (p_osc_irq) else $error("oscillator interrupt wrong");

   property p_rx_on;
      @(posedge clk) disable iff (!rst_n)
      (op_ctrl[`RFMC_OPC_EN] && op_ctrl[`RFMC_OPC_RX_EN]) |=> rx_on;
   endproperty
   a_rx_on: assert property (p_rx_on) else $error("receiver not switched on");

   property p_wake_mode;
      @(posedge clk) disable iff (!rst_n)
      (op_ctrl == (8'h01 << `RFMC_OPC_WU)) |=> (lp_osc_en && !osc_en);
   endproperty
   a_wake_mode: assert property (p_wake_mode) else $error("wake bit alone not wake mode");

   property p_wake_irq;
      @(posedge clk) disable iff (!rst_n)
      wake_irq |-> $past(meas.valid) && $past(state_q == RFMC_WAKE);
   endproperty
   a_wake_irq: assert property (p_wake_irq) else $error("wake interrupt without measurement");

   property p_single_drv;
      @(posedge clk) disable iff (!rst_n)
      (rx_input_b && tx_on) |-> (antenna_driver_out_a == `RFMC_SEG_NONE);
   endproperty
   a_single_drv: assert property (p_single_drv) else $error("unselected driver active");

   property p_min_res;
      @(posedge clk) disable iff (!rst_n)
      (tx_d && !mod_active && !cfg_q.single_drv && cfg_q.d_res == `RFMC_DRES_RESET)
         |=> (antenna_driver_out_a == `RFMC_SEG_ALL);
   endproperty
   a_min_res: assert property (p_min_res) else $error("default code not all segments");

   property p_ook;
      @(posedge clk) disable iff (!rst_n)
      (mod_active && cfg_q.modulation_type_select == RFMC_MOD_OOK)
         |=> (antenna_driver_out_a == `RFMC_SEG_NONE && !am_supply_en);
   endproperty
   a_ook: assert property (p_ook) else $error("OOK did not stop drivers");
endmodule : rfmc_mode_ctrl

// *** common/rfmc_cfg.svh ***
// Constants for the reader front end mode controller
`ifndef RFMC_CFG_SVH
`define RFMC_CFG_SVH
`define RFMC_CLK_MHZ      25
`define RFMC_OPC_W        8
`define RFMC_OPC_RESET    8'h00
`define RFMC_OPC_EN       7
`define RFMC_OPC_RX_EN    6
`define RFMC_OPC_TX_EN    3
`define RFMC_OPC_WU       2
`define RFMC_SEG_N        8
`define RFMC_SEG_ALL      8'hff
`define RFMC_SEG_LSB      8'h01
`define RFMC_SEG_NONE     8'h00
`define RFMC_DRES_MAXSH   4'h7
`define RFMC_DRES_RESET   4'h0
`define RFMC_WU_TICK_US   1000
`define RFMC_PER_ONE      8'h01
`endif

// *** common/rfmc_pkg.sv ***
// Types for the reader front end mode controller
package rfmc_pkg;
   typedef enum logic [2:0] {
      RFMC_PDOWN = 3'b001,
      RFMC_READY = 3'b010,
      RFMC_WAKE  = 3'b100
   } rfmc_state_t;

   typedef enum logic {
      RFMC_MOD_OOK = 1'b0,
      RFMC_MOD_AM  = 1'b1
   } rfmc_mod_t;

   typedef struct packed {
      logic       single_drv;
      logic       alt_driver_select;
      rfmc_mod_t  modulation_type_select;
      logic [3:0] d_res;
   } rfmc_drv_cfg_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] phase;
      logic [7:0] amplitude;
   } rfmc_meas_t;
endpackage : rfmc_pkg

// *** verif/rfmc_host_model.sv ***
// Host side model: writes operation control and driver configuration
`timescale 1ns/1ps
module rfmc_host_model (
   input  wire  logic              clk,
   output logic [7:0]              op_ctrl,
   output rfmc_pkg::rfmc_drv_cfg_t drv_cfg,
   output logic                    cfg_wr,
   output logic                    buf_req
);
   import rfmc_pkg::*;
   // Quiet host after power-up
   initial begin
      op_ctrl = 8'h00;
      drv_cfg = '0;
      cfg_wr  = 1'b0;
      buf_req = 1'b0;
   end
   // Configuration written first, IO and regulator setup before any mode change
   task automatic write_cfg(input rfmc_drv_cfg_t c);
      @(negedge clk);
      drv_cfg = c;
      cfg_wr  = 1'b1;
      @(negedge clk);
      cfg_wr  = 1'b0;
      drv_cfg = ~c; // Released lines never show the old value
   endtask : write_cfg
   // Mode written only after tuning and RC calibration are done
   task automatic write_op(input logic [7:0] v, input logic br);
      @(negedge clk);
      op_ctrl = v;
      buf_req = br;
   endtask : write_op
endmodule : rfmc_host_model

// *** verif/rfmc_mode_ctrl_tb_top.sv ***
// Self-checking bench for the mode and transmit driver controller
`timescale 1ns/1ps
module rfmc_mode_ctrl_tb_top;
   import rfmc_pkg::*;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   logic          osc_ok = 1'b0, mod_active = 1'b0, wake_src_amp = 1'b0;
   logic [7:0]    wake_period = 8'h01, wake_ref = 8'h00, wake_delta = 8'h00, dv, df;
   rfmc_meas_t    meas = '0;
   logic [7:0]    op_ctrl, out_a, out_b;
   rfmc_drv_cfg_t drv_cfg, c;
   logic [2:0]    mode;
   logic          cfg_wr, buf_req, osc_en, regulator_en, aat_out_en, lp_osc_en, rx_on, tx_on, buf_grant;
   logic          osc_stable_irq, meas_start, wake_irq, rx_input_b, am_supply_en;
   integer        fail_count = 0, checked = 0, seed = 32'h79598424, n, p;
   logic [1:0]    exp_q[$];
   logic [7:0]    ops[7] = '{8'h80, 8'hc0, 8'h88, 8'h48, 8'h04, 8'h0c, 8'h00};
   always #20 clk = ~clk;
   rfmc_host_model rfmc_host_model_i (.clk(clk), .op_ctrl(op_ctrl), .drv_cfg(drv_cfg), .cfg_wr(cfg_wr),
      .buf_req(buf_req));
   rfmc_mode_ctrl #(.TICK_CYC(4)) rfmc_mode_ctrl_i (.clk(clk), .rst_n(rst_n), .op_ctrl(op_ctrl),
      .drv_cfg(drv_cfg), .cfg_wr(cfg_wr), .buf_req(buf_req), .osc_ok(osc_ok), .mod_active(mod_active),
      .wake_period(wake_period), .wake_src_amp(wake_src_amp), .wake_ref(wake_ref), .wake_delta(wake_delta),
      .meas(meas), .mode(mode), .osc_en(osc_en), .regulator_en(regulator_en), .aat_out_en(aat_out_en),
      .lp_osc_en(lp_osc_en), .rx_on(rx_on), .tx_on(tx_on), .buf_grant(buf_grant),
      .osc_stable_irq(osc_stable_irq), .meas_start(meas_start), .wake_irq(wake_irq),
      .antenna_driver_out_a(out_a), .antenna_driver_out_b(out_b), .rx_input_b(rx_input_b),
      .am_supply_en(am_supply_en));
   // Compare one result against its expectation
   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Expected mode outputs for an operation control value
   function automatic logic [9:0] exp_st(input logic [7:0] op, input logic br);
      logic r;
      logic w;
      r = op[7];
      w = (op == 8'h04);
      return {w, r, !r && !w, r, r, r, w, r & op[6], r & op[3], r & br};
   endfunction : exp_st
   // Expected driver outputs from configuration, transmit enable and modulation
   function automatic logic [17:0] exp_drv(input rfmc_drv_cfg_t k, input logic tx, input logic ma);
      logic [7:0] m;
      logic       am;
      am = (k.modulation_type_select == RFMC_MOD_AM);
      m = (k.d_res > 4'h7) ? 8'h01 : (8'hff >> k.d_res);
      if (!tx || (ma && !am)) m = 8'h00;
      return {k.single_drv & k.alt_driver_select, tx & ma & am,
         (k.single_drv && k.alt_driver_select) ? 8'h00 : m, (k.single_drv && !k.alt_driver_select) ? 8'h00 : m};
   endfunction : exp_drv
   // Write the mode and check the state outputs one cycle later
   task automatic set_op(input logic [7:0] v, input logic br);
      rfmc_host_model_i.write_op(v, br);
      @(negedge clk);
      chk("mode outputs", 18'(exp_st(v, br)), 18'({mode, osc_en, regulator_en, aat_out_en, lp_osc_en, rx_on, tx_on,
         buf_grant}));
   endtask : set_op
   // Interrupt pulses are matched against the oldest expected one
   always @(negedge clk) begin
      if (rst_n && (osc_stable_irq !== 1'b0 || wake_irq !== 1'b0)) begin
         if (exp_q.size() == 0) chk("interrupt", 18'h0, {16'h0, wake_irq, osc_stable_irq});
         else chk("interrupt", {16'h0, exp_q.pop_front()}, {16'h0, wake_irq, osc_stable_irq});
      end
   end
   // Verdict and end of run
   task automatic report_and_stop;
      if (exp_q.size() != 0) fail_count++;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   // Watchdog well beyond the expected run length
   initial begin
      #(40 * 20000);
      fail_count++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      chk("reset drivers", 18'h0, {rx_input_b, am_supply_en, out_a, out_b});
      c = '{1'b1, 1'b1, RFMC_MOD_AM, 4'h2};
      rfmc_host_model_i.write_cfg(c);
      set_op(8'h00, 1'b1);
      $display("test power-down done");
      set_op(8'h88, 1'b1);
      chk("config from power-down", exp_drv(c, 1'b1, 1'b0), {rx_input_b, am_supply_en, out_a, out_b});
      exp_q.push_back(2'b01);
      osc_ok = 1'b1;
      repeat (4) @(negedge clk);
      osc_ok = 1'b0;
      foreach (ops[i]) set_op(ops[i], i[0]);
      $display("test modes done");
      set_op(8'h88, 1'b0);
      for (int i = 0; i < 16; i++) begin
         c = rfmc_drv_cfg_t'(7'($random(seed)));
         c.d_res = i[3:0];
         rfmc_host_model_i.write_cfg(c);
         mod_active = 1'($random(seed));
         @(negedge clk);
         chk("drivers", exp_drv(c, 1'b1, mod_active), {rx_input_b, am_supply_en, out_a, out_b});
      end
      mod_active = 1'b0;
      $display("test drivers done");
      p = 1 + ($unsigned($random(seed)) % 3);
      wake_period = 8'(p);
      set_op(8'h04, 1'b1);
      n = 0;
      while (meas_start !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk("measurement spacing", 18'(4 * p), 18'(n));
      for (int i = 0; i < 8; i++) begin
         wake_src_amp = i[0];
         wake_ref = 8'($random(seed));
         wake_delta = 8'($random(seed)) & 8'h1f;
         meas = {1'b1, 16'($random(seed))};
         if (i == 2) meas.phase = wake_ref;
         dv = i[0] ? meas.amplitude : meas.phase;
         df = (dv > wake_ref) ? dv - wake_ref : wake_ref - dv;
         if (df > wake_delta) exp_q.push_back(2'b10);
         @(negedge clk);
         meas.valid = 1'b0;
         @(negedge clk);
      end
      set_op(8'h0c, 1'b0);
      $display("test wake-up done");
      // Reset in mid-run while ready: everything back to defaults
      set_op(8'h88, 1'b1);
      rst_n = 1'b0;
      @(negedge clk);
      chk("reset modes", 18'(exp_st(8'h00, 1'b0)), 18'({mode, osc_en, regulator_en, aat_out_en, lp_osc_en, rx_on,
         tx_on, buf_grant}));
      chk("mid-run reset drivers", 18'h0, {rx_input_b, am_supply_en, out_a, out_b});
      rst_n = 1'b1;
      set_op(8'h88, 1'b0);
      c = '{1'b0, 1'b0, RFMC_MOD_OOK, 4'h0};
      chk("default drivers", exp_drv(c, 1'b1, 1'b0), {rx_input_b, am_supply_en, out_a, out_b});
      set_op(8'h00, 1'b0);
      $display("test reset done");
      repeat (2) @(negedge clk);
      report_and_stop();
   end
endmodule : rfmc_mode_ctrl_tb_top
